// ### sim/spcc_prom_model.sv
// Behavioural three-wire serial PROM that answers the controller's link pins.
`timescale 1ns/100ps
module spcc_prom_model
  import spcc_pkg::*;
#(
  parameter int BUSY_NS = 400
)
(
  input  wire logic         sys_clk_in,
  input  wire spcc_pin_type pins_in,
  input  wire logic         present_in,
  input  wire logic         pull_high_in,
  output logic              serial_out
);
  logic [7:0]  mem [0:511];
  logic [19:0] shreg = 20'h0_0000;
  logic [1:0]  op_q = 2'h0;
  logic [8:0]  addr_q = 9'h000;
  logic [7:0]  rd_q = 8'h00;
  logic        rd_bit = 1'b0;
  logic        wr_en = 1'b0;
  logic        polling = 1'b0;
  int          nbits = 0;
  realtime     ready_at = 0;

  initial
  begin
    serial_out = 1'b0;
    for (int i = 0; i < 512; i++)
      mem[i] = (i == 0) ? 8'hA5 : (i[7:0] ^ 8'h5A);
  end

  always @(posedge pins_in.cs)
    nbits = 0;

  // Bits are taken on the rising clock edge, start bit first.
  always @(posedge pins_in.sclk)
  begin
    if (present_in && pins_in.cs && !polling)
    begin
      if (nbits >= 12 && nbits < 20 && op_q == 2'h2)
        rd_bit = rd_q[19 - nbits];
      shreg = {shreg[18:0], pins_in.sdo};
      nbits++;
      if (nbits == 12)
      begin
        op_q = shreg[10:9];
        addr_q = shreg[8:0];
        rd_q = mem[shreg[8:0]];
      end
    end
  end

  // Instructions act when the chip select falls.
  always @(negedge pins_in.cs)
  begin
    if (polling || !present_in)
      polling = 1'b0;
    else if (nbits >= 12 && op_q == 2'h0 && addr_q[8:7] == 2'h3)
      wr_en = 1'b1;
    else if (nbits >= 12 && op_q == 2'h0 && addr_q[8:7] == 2'h0)
      wr_en = 1'b0;
    else if (nbits >= 12 && op_q != 2'h2)
    begin
      for (int i = 0; i < 512; i++)
      begin
        if (wr_en && (op_q == 2'h0 || i == int'(addr_q)))
          mem[i] = (op_q == 2'h3 || (op_q == 2'h0 && addr_q[8:7] == 2'h2)) ? 8'hFF : shreg[7:0];
      end
      polling = 1'b1;
      ready_at = $realtime + (wr_en ? BUSY_NS : 0);
    end
  end

  // A released line shows a toggling pattern rather than its last value.
  always @(posedge sys_clk_in)
  begin
    if (!present_in)
      serial_out <= pull_high_in;
    else if (pins_in.cs && polling)
      serial_out <= ($realtime >= ready_at);
    else if (pins_in.cs && nbits > 12 && op_q == 2'h2)
      serial_out <= rd_bit;
    else
      serial_out <= ~serial_out;
  end
endmodule // spcc_prom_model

// ### sim/tb_top.sv
// Self-checking bench for the serial PROM command controller.
`timescale 1ns/100ps
module tb_top
  import spcc_pkg::*;
;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h0000_0000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_rdata;
  logic         prom_di;
  spcc_pin_type prom_pins;
  spcc_cfg_type cfg;
  logic         cfg_valid;
  logic         present = 1'b1;
  logic         pull_high = 1'b0;
  logic [7:0]   shadow [0:511];
  logic [7:0]   data_exp = 8'h00;
  logic         loaded_exp = 1'b1;
  logic [15:0]  lfsr = 16'h004F;
  int           bad_count = 0;
  int           checks_done = 0;
  int           cfg_pulses = 0;

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  spcc_top #(.TIMEOUT_CYCLES(200)) dut_u (
    .sys_clk_in           (sys_clk),
    .rst_in               (rst),
    .reg_addr_in          (reg_addr),
    .reg_wdata_in         (reg_wdata),
    .reg_wr_in            (reg_wr),
    .reg_rd_in            (reg_rd),
    .reg_rdata_out        (reg_rdata),
    .prom_serial_input_in (prom_di),
    .prom_pins_out        (prom_pins),
    .cfg_out              (cfg),
    .cfg_valid_out        (cfg_valid)
  );

  spcc_prom_model #(.BUSY_NS(400)) prom_u (
    .sys_clk_in   (sys_clk),
    .pins_in      (prom_pins),
    .present_in   (present),
    .pull_high_in (pull_high),
    .serial_out   (prom_di)
  );

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] exp_init(input logic [8:0] i);
    return (i == 9'h000) ? 8'hA5 : (i[7:0] ^ 8'h5A);
  endfunction

  function automatic logic tmo_expected(input spcc_cmd_type op, input logic pres, input logic pull);
    return !pres && !pull && (op inside {CMD_WRITE, CMD_WRITE_EVERY_LOCATION, CMD_ERASE, CMD_ERASE_EVERY_LOCATION});
  endfunction

  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    st = 32'h8000_0000;
    while (st[31] !== 1'b0 && n < 10000)
    begin
      reg_read(8'h30, st);
      n++;
    end
    if (n >= 10000)
    begin
      bad_count++;
      $display("BAD %0t busy never cleared", $time);
      complete_run();
    end
  endtask

  task automatic set_data(input logic [7:0] d);
    reg_write(8'h34, {24'h00_0000, d});
    data_exp = d;
  endtask

  task automatic do_cmd(input spcc_cmd_type op, input logic [8:0] a);
    logic [31:0] st;
    logic        tmo;
    tmo = tmo_expected(op, present, pull_high);
    reg_write(8'h30, {1'b1, op, 19'h0_0000, a});
    reg_read(8'h30, st);
    check(st[31], 1'b1);
    reg_write(8'h34, {24'h00_0000, ~data_exp});
    wait_idle(st);
    check(st, {1'b0, op, 17'h0_0000, tmo, loaded_exp, a});
    if (op == CMD_READ)
      data_exp = present ? shadow[a] : {8{pull_high}};
    reg_read(8'h34, st);
    check(st, {24'h00_0000, data_exp});
  endtask

  always @(posedge sys_clk)
  begin
    if (cfg_valid === 1'b1)
    begin
      cfg_pulses++;
      check({24'h00_0000, cfg.value}, {24'h00_0000, shadow[cfg.index]});
    end
  end

  initial
  begin
    logic [31:0] st;
    logic [8:0]  a;
    int          pulses_before;
    for (int i = 0; i < 512; i++)
      shadow[i] = exp_init(i[8:0]);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(8'h30, st);
    check(st[31], 1'b1);
    wait_idle(st);
    check(st[9], 1'b1);
    check(cfg_pulses, 16);
    reg_read(8'h34, st);
    check(st, 32'h0000_0000);
    reg_read(8'h38, st);
    check(st, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
    begin
      lfsr = lfsr_step(lfsr);
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : lfsr[8:0];
      do_cmd(CMD_READ, a);
    end
    lfsr = lfsr_step(lfsr);
    a = lfsr[8:0];
    set_data(lfsr[15:8]);
    do_cmd(CMD_WRITE, a);
    do_cmd(CMD_READ, a);
    do_cmd(CMD_ERASE_WRITE_ENABLE, a);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_step(lfsr);
      a = (i == 0) ? 9'h1FF : lfsr[8:0];
      set_data(lfsr[15:8]);
      do_cmd(CMD_WRITE, a);
      shadow[a] = data_exp;
      do_cmd(CMD_READ, a);
    end
    do_cmd(CMD_ERASE, a);
    shadow[a] = 8'hFF;
    do_cmd(CMD_READ, a);
    do_cmd(CMD_ERASE_WRITE_DISABLE, a);
    set_data(8'h3C);
    do_cmd(CMD_WRITE, a);
    do_cmd(CMD_READ, a);
    do_cmd(CMD_ERASE_WRITE_ENABLE, a);
    set_data(8'hC3);
    do_cmd(CMD_WRITE_EVERY_LOCATION, a);
    for (int i = 0; i < 512; i++)
      shadow[i] = 8'hC3;
    do_cmd(CMD_READ, 9'h155);
    do_cmd(CMD_ERASE_EVERY_LOCATION, a);
    for (int i = 0; i < 512; i++)
      shadow[i] = 8'hFF;
    do_cmd(CMD_READ, 9'h0AA);
    pulses_before = cfg_pulses;
    do_cmd(CMD_RELOAD, a);
    check(cfg_pulses, pulses_before);
    set_data(8'hA5);
    do_cmd(CMD_WRITE, 9'h000);
    shadow[0] = 8'hA5;
    do_cmd(CMD_RELOAD, a);
    check(cfg_pulses, pulses_before + 16);
    do_cmd(CMD_ERASE, 9'h000);
    shadow[0] = 8'hFF;
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    data_exp = 8'h00;
    loaded_exp = 1'b0;
    wait_idle(st);
    check(st[9], 1'b0);
    present <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      pull_high <= p[0];
      for (int c = 0; c < 8; c++)
        do_cmd(spcc_cmd_type'(c[2:0]), 9'h0F0);
    end
    complete_run();
  end
endmodule // tb_top

// ### src/spcc_defs.svh
// Constants of the serial PROM command controller.
//
// Contract
// - Writing one to busy runs the selected command; busy holds until it finishes.
// - Busy reads high after reset while configuration is loaded, then clears.
// - Command field decodes read, disable, enable, write, write all, erase, erase all, reload.
// - Read fetches the addressed byte into the data register.
// - Disable sends the instruction that blocks later erase and write.
// - Enable sends the instruction that permits erase and write.
// - Single write stores the data byte at the given address.
// - Write all stores the data byte into every location.
// - Single erase clears the location at the given address.
// - Erase all starts a bulk erase of the whole array.
// - Reload rereads configuration; a first byte other than A5h fails it.
// - A failed reload leaves configuration contents untouched.
// - No answer within 30 ms abandons the command and sets the time-out flag.
// - A write with no memory and the input line low keeps busy set until the time-out clears it.
// - With the input line high, busy clears once the frame is shifted out.
// - Only write, write all, erase and erase all can time out.
// - Data-loaded is set after a valid memory loaded, at start or by reload.
// - The 9-bit address field addresses bytes for single-location commands.
// - The data register holds the byte in bits 7:0; upper bits read zero.
`ifndef SPCC_DEFS_SVH
`define SPCC_DEFS_SVH
`define SPCC_CMD_OFS      8'h30
`define SPCC_DATA_OFS     8'h34
`define SPCC_BUSY_BIT     31
`define SPCC_OPC_HI       30
`define SPCC_OPC_LO       28
`define SPCC_TMO_BIT      10
`define SPCC_LOADED_BIT   9
`define SPCC_ADDR_HI      8
`define SPCC_DATA_HI      7
`define SPCC_ZERO_WORD    32'h0000_0000
`define SPCC_CLK_MHZ      250
`define SPCC_TIMEOUT_MS   30
`define SPCC_SK_HALF_NS   64
`define SPCC_SK_HALF      (`SPCC_SK_HALF_NS * `SPCC_CLK_MHZ / 1000)
`define SPCC_TMO_W        23
`define SPCC_START_BIT    1'b1
`define SPCC_OP_READ      2'h2
`define SPCC_OP_WRITE     2'h1
`define SPCC_OP_ERASE     2'h3
`define SPCC_OP_EXT       2'h0
`define SPCC_EXT_WDS      2'h0
`define SPCC_EXT_WRITE_EVERY_LOCATION     2'h1
`define SPCC_EXT_ERASE_EVERY_LOCATION     2'h2
`define SPCC_EXT_WEN      2'h3
`define SPCC_EXT_PAD      7'h00
`define SPCC_NO_DATA      8'h00
`define SPCC_LEN_SHORT    5'h0C
`define SPCC_LEN_LONG     5'h14
`define SPCC_RD_BITS      5'h08
`define SPCC_BOOT_FRAME   20'hC_0000
`define SPCC_MARKER       8'hA5
`define SPCC_MARKER_ADDR  9'h000
`define SPCC_ADDR_STEP    9'h001
`define SPCC_CFG_LAST     9'h010
`endif

// ### src/spcc_pkg.sv
// Types shared by the serial PROM command controller.
package spcc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_SHIFT = 3'h2,
    ST_READ  = 3'h3,
    ST_CSLOW = 3'h4,
    ST_POLL  = 3'h5,
    ST_NEXT  = 3'h6
  } spcc_state_type;
  typedef enum logic [2:0] {
    CMD_READ                 = 3'h0,
    CMD_ERASE_WRITE_DISABLE  = 3'h1,
    CMD_ERASE_WRITE_ENABLE   = 3'h2,
    CMD_WRITE                = 3'h3,
    CMD_WRITE_EVERY_LOCATION = 3'h4,
    CMD_ERASE                = 3'h5,
    CMD_ERASE_EVERY_LOCATION = 3'h6,
    CMD_RELOAD               = 3'h7
  } spcc_cmd_type;
  typedef struct packed {
    logic cs;
    logic sclk;
    logic sdo;
  } spcc_pin_type;
  typedef struct packed {
    logic [8:0] index;
    logic [7:0] value;
  } spcc_cfg_type;
endpackage

// ### src/spcc_top.sv
// Serial PROM command controller with register port and three-wire link.
`timescale 1ns/100ps
`include "spcc_defs.svh"
module spcc_top
  import spcc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `SPCC_TIMEOUT_MS * `SPCC_CLK_MHZ * 1000
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  input  wire logic        prom_serial_input_in,
  output spcc_pin_type     prom_pins_out,
  output spcc_cfg_type     cfg_out,
  output logic             cfg_valid_out
);

  localparam logic [4:0] SK_LAST = 5'(`SPCC_SK_HALF - 1);
  localparam logic [`SPCC_TMO_W-1:0] TMO_LAST = `SPCC_TMO_W'(TIMEOUT_CYCLES - 1);

  spcc_state_type          st;
  spcc_cmd_type            run_op;
  spcc_cmd_type            opcode;
  logic                    busy;
  logic [8:0]              addr;
  logic [7:0]              data8;
  logic                    tmo_flag;
  logic                    loaded;
  logic [19:0]             shreg;
  logic [4:0]              bit_cnt;
  logic [4:0]              ph_cnt;
  logic [`SPCC_TMO_W-1:0]  tmo_cnt;
  logic [8:0]              cur_addr;
  logic [7:0]              rd_byte;
  logic                    cs;
  logic                    sk;
  logic                    di_meta;
  logic                    di_sync;
  logic                    marker_ok;
  logic                    fin;
  logic                    tmo_hit;
  logic                    load_ok;
  logic                    rd_done;
  logic                    tick;
  logic                    cmd_wr;
  logic                    start_user;
  spcc_cmd_type            wop;

  function automatic logic [19:0] frame_of(input spcc_cmd_type c, input logic [8:0] a,
                                           input logic [7:0] d);
    logic [19:0] f;
    f = {`SPCC_START_BIT, `SPCC_OP_READ, a, `SPCC_NO_DATA};
    unique case (c)
      CMD_READ, CMD_RELOAD:
        f = {`SPCC_START_BIT, `SPCC_OP_READ, ((c == CMD_RELOAD) ? `SPCC_MARKER_ADDR : a), `SPCC_NO_DATA};
      CMD_ERASE_WRITE_DISABLE:
        f = {`SPCC_START_BIT, `SPCC_OP_EXT, `SPCC_EXT_WDS, `SPCC_EXT_PAD, `SPCC_NO_DATA};
      CMD_ERASE_WRITE_ENABLE:
        f = {`SPCC_START_BIT, `SPCC_OP_EXT, `SPCC_EXT_WEN, `SPCC_EXT_PAD, `SPCC_NO_DATA};
      CMD_WRITE:
        f = {`SPCC_START_BIT, `SPCC_OP_WRITE, a, d};
      CMD_WRITE_EVERY_LOCATION:
        f = {`SPCC_START_BIT, `SPCC_OP_EXT, `SPCC_EXT_WRITE_EVERY_LOCATION, `SPCC_EXT_PAD, d};
      CMD_ERASE:
        f = {`SPCC_START_BIT, `SPCC_OP_ERASE, a, `SPCC_NO_DATA};
      CMD_ERASE_EVERY_LOCATION:
        f = {`SPCC_START_BIT, `SPCC_OP_EXT, `SPCC_EXT_ERASE_EVERY_LOCATION, `SPCC_EXT_PAD, `SPCC_NO_DATA};
    endcase
    return f;
  endfunction

  function automatic logic [4:0] len_of(input spcc_cmd_type c);
    return (c == CMD_WRITE || c == CMD_WRITE_EVERY_LOCATION) ? `SPCC_LEN_LONG : `SPCC_LEN_SHORT;
  endfunction

  function automatic logic needs_poll(input spcc_cmd_type c);
    return c inside {CMD_WRITE, CMD_WRITE_EVERY_LOCATION, CMD_ERASE, CMD_ERASE_EVERY_LOCATION};
  endfunction

  // Register port decode.
  assign cmd_wr     = reg_wr_in && (reg_addr_in == `SPCC_CMD_OFS);
  assign wop        = spcc_cmd_type'(reg_wdata_in[`SPCC_OPC_HI:`SPCC_OPC_LO]);
  assign start_user = cmd_wr && reg_wdata_in[`SPCC_BUSY_BIT] && !busy;
  assign tick       = (ph_cnt == SK_LAST);
  assign prom_pins_out = '{cs: cs, sclk: sk, sdo: shreg[19]};

  // Input line synchroniser.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      di_meta <= 1'b0;
      di_sync <= 1'b0;
    end
    else
    begin
      di_meta <= prom_serial_input_in;
      di_sync <= di_meta;
    end
  end

  // Serial clock phase divider.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || st == ST_IDLE || st == ST_NEXT || tick)
      ph_cnt <= 5'h00;
    else
      ph_cnt <= ph_cnt + 5'h01;
  end

  // Command sequencer and link pins.
  always_ff @(posedge sys_clk_in)
  begin
    fin           <= 1'b0;
    tmo_hit       <= 1'b0;
    load_ok       <= 1'b0;
    rd_done       <= 1'b0;
    cfg_valid_out <= 1'b0;
    if (rst_in)
    begin
      st        <= ST_START;
      run_op    <= CMD_RELOAD;
      shreg     <= `SPCC_BOOT_FRAME;
      bit_cnt   <= `SPCC_LEN_SHORT;
      cs        <= 1'b0;
      sk        <= 1'b0;
      cur_addr  <= `SPCC_MARKER_ADDR;
      rd_byte   <= `SPCC_NO_DATA;
      tmo_cnt   <= '0;
      marker_ok <= 1'b0;
      cfg_out   <= '0;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          cs <= 1'b0;
          sk <= 1'b0;
          if (start_user)
          begin
            run_op    <= wop;
            shreg     <= frame_of(wop, reg_wdata_in[`SPCC_ADDR_HI:0], data8);
            bit_cnt   <= len_of(wop);
            cur_addr  <= `SPCC_MARKER_ADDR;
            marker_ok <= 1'b0;
            st        <= ST_START;
          end
        end
        ST_START:
        begin
          if (tick)
          begin
            cs <= 1'b1;
            st <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick && !sk)
            sk <= 1'b1;
          else if (tick)
          begin
            sk      <= 1'b0;
            shreg   <= {shreg[18:0], 1'b0};
            bit_cnt <= bit_cnt - 5'h01;
            if (bit_cnt == 5'h01)
            begin
              if (run_op == CMD_READ || run_op == CMD_RELOAD)
              begin
                bit_cnt <= `SPCC_RD_BITS;
                st      <= ST_READ;
              end
              else if (needs_poll(run_op))
              begin
                cs <= 1'b0;
                st <= ST_CSLOW;
              end
              else
                st <= ST_NEXT;
            end
          end
        end
        ST_READ:
        begin
          if (tick && !sk)
            sk <= 1'b1;
          else if (tick)
          begin
            sk      <= 1'b0;
            rd_byte <= {rd_byte[6:0], di_sync};
            bit_cnt <= bit_cnt - 5'h01;
            if (bit_cnt == 5'h01)
              st <= ST_NEXT;
          end
        end
        ST_CSLOW:
        begin
          if (tick)
          begin
            cs      <= 1'b1;
            tmo_cnt <= '0;
            st      <= ST_POLL;
          end
        end
        ST_POLL:
        begin
          tmo_cnt <= tmo_cnt + `SPCC_TMO_W'(1);
          if (tick && di_sync)
            st <= ST_NEXT;
          else if (tmo_cnt == TMO_LAST)
          begin
            tmo_hit <= 1'b1;
            fin     <= 1'b1;
            cs      <= 1'b0;
            st      <= ST_IDLE;
          end
        end
        ST_NEXT:
        begin
          cs <= 1'b0;
          sk <= 1'b0;
          if (run_op == CMD_RELOAD && cur_addr == `SPCC_MARKER_ADDR)
          begin
            if (rd_byte == `SPCC_MARKER)
            begin
              marker_ok <= 1'b1;
              cur_addr  <= cur_addr + `SPCC_ADDR_STEP;
              shreg     <= frame_of(CMD_READ, cur_addr + `SPCC_ADDR_STEP, `SPCC_NO_DATA);
              bit_cnt   <= `SPCC_LEN_SHORT;
              st        <= ST_START;
            end
            else
            begin
              fin <= 1'b1;
              st  <= ST_IDLE;
            end
          end
          else if (run_op == CMD_RELOAD)
          begin
            cfg_valid_out <= 1'b1;
            cfg_out       <= '{index: cur_addr, value: rd_byte};
            if (cur_addr == `SPCC_CFG_LAST)
            begin
              load_ok <= 1'b1;
              fin     <= 1'b1;
              st      <= ST_IDLE;
            end
            else
            begin
              cur_addr <= cur_addr + `SPCC_ADDR_STEP;
              shreg    <= frame_of(CMD_READ, cur_addr + `SPCC_ADDR_STEP, `SPCC_NO_DATA);
              bit_cnt  <= `SPCC_LEN_SHORT;
              st       <= ST_START;
            end
          end
          else
          begin
            rd_done <= (run_op == CMD_READ);
            fin     <= 1'b1;
            st      <= ST_IDLE;
          end
        end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // Busy flag.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      busy <= 1'b1;
    else if (start_user)
      busy <= 1'b1;
    else if (fin)
      busy <= 1'b0;
  end

  // Command fields, held while busy.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      opcode <= CMD_READ;
      addr   <= 9'h000;
    end
    else if (cmd_wr && !busy)
    begin
      opcode <= wop;
      addr   <= reg_wdata_in[`SPCC_ADDR_HI:0];
    end
  end

  // Data byte register.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      data8 <= `SPCC_NO_DATA;
    else if (rd_done)
      data8 <= rd_byte;
    else if (reg_wr_in && reg_addr_in == `SPCC_DATA_OFS && !busy)
      data8 <= reg_wdata_in[`SPCC_DATA_HI:0];
  end

  // Status flags.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      tmo_flag <= 1'b0;
      loaded   <= 1'b0;
    end
    else
    begin
      if (tmo_hit)
        tmo_flag <= 1'b1;
      else if (start_user)
        tmo_flag <= 1'b0;
      if (load_ok)
        loaded <= 1'b1;
    end
  end

  // Read data, valid the cycle after the strobe only.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !reg_rd_in)
      reg_rdata_out <= `SPCC_ZERO_WORD;
    else if (reg_addr_in == `SPCC_CMD_OFS)
    begin
      reg_rdata_out                                 <= `SPCC_ZERO_WORD;
      reg_rdata_out[`SPCC_BUSY_BIT]                 <= busy;
      reg_rdata_out[`SPCC_OPC_HI:`SPCC_OPC_LO]      <= opcode;
      reg_rdata_out[`SPCC_TMO_BIT]                  <= tmo_flag;
      reg_rdata_out[`SPCC_LOADED_BIT]               <= loaded;
      reg_rdata_out[`SPCC_ADDR_HI:0]                <= addr;
    end
    else if (reg_addr_in == `SPCC_DATA_OFS)
      reg_rdata_out <= {24'h00_0000, data8};
    else
      reg_rdata_out <= `SPCC_ZERO_WORD;
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_start_busy;
    start_user |=> busy ##1 busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not held after start");

  property p_reset_busy;
    $past(rst_in) |-> busy && st == ST_START && run_op == CMD_RELOAD;
  endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("no boot load after reset");

  property p_frame_read;
    (start_user && wop == CMD_READ) |=> shreg[19:17] == {`SPCC_START_BIT, `SPCC_OP_READ};
  endproperty
  a_frame_read: assert property (p_frame_read) else $error("read frame header wrong");

  property p_read_data;
    rd_done |=> data8 == $past(rd_byte) && !busy;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read byte not stored");

  property p_tmo_clear;
    $rose(tmo_flag) |-> !busy && $past(st, 2) == ST_POLL;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("time-out without busy clear");

  property p_poll_ops;
    st == ST_POLL |-> needs_poll(run_op);
  endproperty
  a_poll_ops: assert property (p_poll_ops) else $error("wrong command can time out");

  property p_ready_exit;
    (st == ST_POLL && tick && di_sync) |=> st == ST_NEXT ##1 st == ST_IDLE ##1 !busy;
  endproperty
  a_ready_exit: assert property (p_ready_exit) else $error("ready not honoured");

  property p_fail_keep;
    cfg_valid_out |-> marker_ok && run_op == CMD_RELOAD;
  endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("config delivered without marker");

  property p_loaded;
    load_ok |=> loaded && !busy;
  endproperty
  a_loaded: assert property (p_loaded) else $error("data loaded not set");

  property p_cs_idle;
    st == ST_IDLE |-> !prom_pins_out.cs && !prom_pins_out.sclk;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("link active while idle");

  c_read: cover property (rd_done);
  c_tmo: cover property (tmo_hit);
  c_load: cover property (load_ok);
  c_fail: cover property (fin && run_op == CMD_RELOAD && !marker_ok);

endmodule // spcc_top
